// File: design/pach_cfg.svh
// Purpose: constants for the parallel asynchronous configuration handshake
// Assumes: one 40 MHz clock, synchronous inputs
// Notes: counts in cycles of mclk
`ifndef PACH_CFG_SVH
`define PACH_CFG_SVH
`define PACH_BUSY_TIME_NS 100
`define PACH_CLK_NS 25
`define PACH_BUSY_CYCLES ((`PACH_BUSY_TIME_NS + `PACH_CLK_NS - 1) / `PACH_CLK_NS)
`define PACH_DATA_W 8
`define PACH_PAGE_W 3
`define PACH_STATUS_BIT 7
`define PACH_PAGE_RST 3'h0
`endif

// File: design/pach_handshake.sv
// Purpose: target-side parallel asynchronous configuration handshake
// Assumes: host inputs synchronous to mclk; byte consumer gives byte_taken
// Notes: flag and data pins released to user I/O (enables low) outside parallel async loading
//   config_done closes the byte window, keeping the flag high until user mode
// Operation
// R1: while read strobe low in parallel async mode, drive ready flag on data line 7.
// R2: flag high when a byte can be accepted, low while busy.
// R3: flag high after power-up before loading and after loading until user mode.
// R4: in other load modes strobe, flag and selects stay tri-stated.
// R5: host ties unused read strobe high.
// R6: selected only when low select is low and high select is high.
// R7: host holds both selects active through loading and initialisation.
// R8: a select the host does not toggle is tied active.
// R9: after parallel async loading the pins revert to user I/O.
// R10: remote update when update source high, local when low.
// R11: drive 3-bit page select naming one of eight pages in upgrade mode.
// R12: update source and page pins are user I/O without upgrade or in active serial.
// R13: byte captured on the write strobe rising edge.
// R14: busy after capture until the byte is consumed; host waits for ready.
`timescale 1ns/10ps
`include "pach_cfg.svh"
module pach_handshake #(
  parameter int DATA_W = `PACH_DATA_W,
  parameter int PAGE_W = `PACH_PAGE_W,
  parameter int BUSY_CYCLES = `PACH_BUSY_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire pach_pkg::pach_mode_type load_mode,
  input wire logic upgrade_enable,
  input wire logic config_done,
  input wire logic user_mode,
  input wire logic read_status_strobe_n,
  input wire logic write_strobe_n,
  input wire logic chip_select_low_n,
  input wire logic chip_select_high,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic byte_taken,
  input wire logic update_source_select,
  input wire logic [PAGE_W-1:0] page_next_in,
  input wire logic page_load,
  output logic [DATA_W-1:0] data_out,
  output logic [DATA_W-1:0] data_oe,
  output logic [DATA_W-1:0] byte_data,
  output logic byte_valid,
  output logic ready_busy_flag,
  output logic ready_busy_oe,
  output logic remote_update,
  output logic [PAGE_W-1:0] memory_page_select,
  output logic memory_page_oe,
  output logic selected
);
  initial begin
    if (DATA_W != 8 || PAGE_W != 3 || BUSY_CYCLES < 1 || BUSY_CYCLES > 255) begin
      $error("pach_handshake: unsupported parameters");
    end
  end

  typedef struct packed {
    pach_pkg::pach_state_type st;
    logic wr_prev;
    logic [7:0] cnt;
    logic [DATA_W-1:0] byte_d;
    logic valid;
    logic [PAGE_W-1:0] page;
  } pach_state_rec_type;

  // state decode shared by the flag and the checks
  function automatic logic st_idle(input pach_pkg::pach_state_type st);
    return st == pach_pkg::PACH_ST_IDLE;
  endfunction : st_idle

  pach_state_rec_type s_reg;
  pach_state_rec_type s_next;

  logic parallel_async_load_mode;
  logic wr_rise;
  logic upgrade_on;
  logic load_open;
  logic status_drive;

  assign parallel_async_load_mode = (load_mode == pach_pkg::PACH_PARALLEL_ASYNC)
    && (s_reg.st != pach_pkg::PACH_ST_USER);
  assign selected = !chip_select_low_n && chip_select_high; // R6
  // no byte once loading is complete, so the flag stays high until user mode
  assign load_open = parallel_async_load_mode && !config_done; // R3
  assign wr_rise = load_open && selected && !s_reg.wr_prev && write_strobe_n; // R13
  assign upgrade_on = upgrade_enable && (load_mode != pach_pkg::PACH_ACTIVE_SERIAL); // R12

  always_comb begin
    s_next = s_reg;
    s_next.wr_prev = write_strobe_n;
    if (page_load && upgrade_on) begin
      s_next.page = page_next_in; // R11
    end
    case (s_reg.st)
      // a byte is only taken while idle; strobes while busy are ignored
      pach_pkg::PACH_ST_IDLE: begin
        if (user_mode) begin
          s_next.st = pach_pkg::PACH_ST_USER; // R9
        end else if (wr_rise) begin
          s_next.byte_d = data_in; // R13
          s_next.valid = 1'b1;
          s_next.cnt = 8'(BUSY_CYCLES);
          s_next.st = pach_pkg::PACH_ST_BUSY; // R14
        end
      end
      // busy for the minimum time and until the byte is consumed
      pach_pkg::PACH_ST_BUSY: begin
        if (s_reg.cnt != 8'h00) begin
          s_next.cnt = s_reg.cnt - 8'h01;
        end
        if (byte_taken) begin
          s_next.valid = 1'b0;
        end
        if ((!s_reg.valid || byte_taken) && s_reg.cnt <= 8'h01) begin
          s_next.st = pach_pkg::PACH_ST_IDLE; // R14
        end
      end
      default: begin
        s_next.valid = 1'b0;
      end
    endcase
  end

  // one register bank for the whole state record
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_reg <= '{st: pach_pkg::PACH_ST_IDLE, wr_prev: 1'b1, cnt: 8'h00,
                 byte_d: 8'h00, valid: 1'b0, page: `PACH_PAGE_RST};
    end else begin
      s_reg <= s_next;
    end
  end

  always_comb begin
    ready_busy_oe = 1'b0;
    ready_busy_flag = 1'b1;
    status_drive = 1'b0;
    if (parallel_async_load_mode) begin
      ready_busy_oe = 1'b1; // R3
      ready_busy_flag = st_idle(s_reg.st); // R2
      status_drive = !read_status_strobe_n; // R1
    end
    // R4 R9: outside ppa the flag and status line enables stay low
  end

  // only the status line is ever driven, the rest stay released
  for (genvar i = 0; i < DATA_W; i++) begin : g_data_line
    if (i == `PACH_STATUS_BIT) begin : g_status
      assign data_oe[i] = status_drive; // R1
      assign data_out[i] = status_drive && ready_busy_flag;
    end else begin : g_other
      assign data_oe[i] = 1'b0;
      assign data_out[i] = 1'b0;
    end
  end

  assign byte_data = s_reg.byte_d;
  assign byte_valid = s_reg.valid;
  assign remote_update = upgrade_on && update_source_select; // R10
  assign memory_page_select = s_reg.page;
  assign memory_page_oe = upgrade_on; // R11

  status_drive_a: assert property (@(posedge mclk) disable iff (rst) // R1
    (parallel_async_load_mode && !read_status_strobe_n) |-> (data_oe[7] && data_out[7] == ready_busy_flag))
    else $error("status not driven on data line 7");
  busy_after_byte_a: assert property (@(posedge mclk) disable iff (rst) // R14
    wr_rise |=> (!ready_busy_flag || !parallel_async_load_mode))
    else $error("not busy after byte capture");
  ready_level_a: assert property (@(posedge mclk) disable iff (rst) // R2
    (parallel_async_load_mode && s_reg.st == pach_pkg::PACH_ST_IDLE) |-> ready_busy_flag)
    else $error("flag low while idle");
  non_ppa_tri_a: assert property (@(posedge mclk) disable iff (rst) // R4
    (load_mode != pach_pkg::PACH_PARALLEL_ASYNC) |-> (!ready_busy_oe && data_oe == 8'h00))
    else $error("pins driven outside parallel async");
  select_gate_a: assert property (@(posedge mclk) disable iff (rst) // R6
    (chip_select_low_n || !chip_select_high) |=> !s_reg.valid || $stable(s_reg.byte_d))
    else $error("byte taken while deselected");
  capture_byte_a: assert property (@(posedge mclk) disable iff (rst) // R13
    (wr_rise && s_reg.st == pach_pkg::PACH_ST_IDLE && !user_mode)
      |=> (byte_valid && byte_data == $past(data_in)))
    else $error("byte not captured on rising write strobe");
  user_release_a: assert property (@(posedge mclk) disable iff (rst) // R9
    (s_reg.st == pach_pkg::PACH_ST_USER) |-> (!ready_busy_oe && data_oe == 8'h00))
    else $error("pins held after user mode");
  remote_pick_a: assert property (@(posedge mclk) disable iff (rst) // R10
    upgrade_on |-> (remote_update == update_source_select))
    else $error("update source misread");
  page_gpio_a: assert property (@(posedge mclk) disable iff (rst) // R12
    (load_mode == pach_pkg::PACH_ACTIVE_SERIAL) |-> (!memory_page_oe && !remote_update))
    else $error("page pins driven in active serial");
  busy_bound_a: assert property (@(posedge mclk) disable iff (rst) // R14
    (s_reg.st == pach_pkg::PACH_ST_BUSY && !s_reg.valid) |-> ##[1:256]
      (s_reg.st != pach_pkg::PACH_ST_BUSY))
    else $error("busy never ends");

  // refusal, flag level, release and page tracking
  busy_refuse_a: assert property (@(posedge mclk) disable iff (rst) // R14
    (s_reg.st == pach_pkg::PACH_ST_BUSY) |=> $stable(byte_data))
    else $error("byte changed while busy");
  busy_flag_a: assert property (@(posedge mclk) disable iff (rst) // R2
    (parallel_async_load_mode && s_reg.st == pach_pkg::PACH_ST_BUSY) |-> !ready_busy_flag)
    else $error("flag high while busy");
  status_release_a: assert property (@(posedge mclk) disable iff (rst) // R1
    read_status_strobe_n |-> !data_oe[`PACH_STATUS_BIT])
    else $error("data line 7 driven without read strobe");
  done_ready_a: assert property (@(posedge mclk) disable iff (rst) // R3
    (parallel_async_load_mode && config_done && st_idle(s_reg.st)) |=> (ready_busy_flag || !parallel_async_load_mode))
    else $error("flag dropped after loading completed");
  page_track_a: assert property (@(posedge mclk) disable iff (rst) // R11
    (page_load && upgrade_on) |=> (memory_page_select == $past(page_next_in)))
    else $error("page select not loaded");

  // main scenarios to reach
  byte_cycle_c: cover property (@(posedge mclk) disable iff (rst)
    wr_rise ##[1:20] (parallel_async_load_mode && ready_busy_flag));
  status_read_c: cover property (@(posedge mclk) disable iff (rst)
    (parallel_async_load_mode && !read_status_strobe_n && !ready_busy_flag));
  user_entry_c: cover property (@(posedge mclk) disable iff (rst)
    (s_reg.st == pach_pkg::PACH_ST_USER));
  remote_sel_c: cover property (@(posedge mclk) disable iff (rst) remote_update);
  done_hold_c: cover property (@(posedge mclk) disable iff (rst)
    (parallel_async_load_mode && config_done && ready_busy_flag));
endmodule : pach_handshake

// File: design/pach_pkg.sv
// Purpose: types for the parallel asynchronous configuration handshake
// Assumes: nothing from pach_cfg.svh, which it does not include
// Notes: load mode and handshake state enums
package pach_pkg;
  typedef enum logic [1:0] {
    PACH_FAST_PARALLEL,
    PACH_PASSIVE_SERIAL,
    PACH_PARALLEL_ASYNC,
    PACH_ACTIVE_SERIAL
  } pach_mode_type;
  typedef enum logic [1:0] {
    PACH_ST_IDLE,
    PACH_ST_BUSY,
    PACH_ST_USER
  } pach_state_type;
endpackage : pach_pkg

// File: sim/pach_host.sv
// Purpose: host model writing one byte per request
// Assumes: drives at the falling edge of mclk
// Notes: bus shows the inverted byte after its hold
`timescale 1ns/10ps
module pach_host (
  input wire logic mclk,
  input wire logic go,
  input wire logic [7:0] byte_in,
  input wire logic ready,
  output logic write_strobe_n,
  output logic [7:0] data_in,
  output logic busy
);
  logic [1:0] step = 2'h0;
  initial begin
    write_strobe_n = 1'b1;
    data_in = 8'h00;
    busy = 1'b0;
  end
  always @(negedge mclk) begin
    case (step)
      2'h0: if (go && ready) begin
        write_strobe_n = 1'b0;
        data_in = byte_in;
        busy = 1'b1;
        step = 2'h1;
      end
      2'h1: begin
        write_strobe_n = 1'b1;
        step = 2'h2;
      end
      2'h2: begin
        data_in = ~data_in;
        step = 2'h3;
      end
      default: if (ready) begin
        busy = 1'b0;
        step = 2'h0;
      end
    endcase
  end
endmodule : pach_host

// File: sim/tb_pach_handshake.sv
// Purpose: self-checking bench for the configuration handshake
// Assumes: host model writes bytes, bench drives the rest
// Notes: xorshift seed 31 gives bytes, pages and consume timing
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb_pach_handshake;
  logic mclk, rst, upg, user, rs_n, ws_n, cs_n, cs, taken, uss, pload, go, hbusy, got, done;
  pach_pkg::pach_mode_type mode;
  logic [7:0] din, dout, doe, bdata, hbyte;
  logic [2:0] page, pnext;
  logic flag, foe, remote, poe, sel, bvalid;
  int bad_count = 0;
  int n_tests = 0;
  logic [31:0] seed = 32'h0000001F;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  function automatic logic exp_sel(input logic [1:0] p);
    return p == 2'h1;
  endfunction : exp_sel
  pach_handshake #(.BUSY_CYCLES(4)) DUT (.mclk(mclk), .rst(rst), .load_mode(mode),
    .upgrade_enable(upg), .config_done(done), .user_mode(user), .read_status_strobe_n(rs_n),
    .write_strobe_n(ws_n), .chip_select_low_n(cs_n), .chip_select_high(cs), .data_in(din),
    .byte_taken(taken), .update_source_select(uss), .page_next_in(pnext),
    .page_load(pload), .data_out(dout), .data_oe(doe), .byte_data(bdata),
    .byte_valid(bvalid), .ready_busy_flag(flag), .ready_busy_oe(foe), .remote_update(remote),
    .memory_page_select(page), .memory_page_oe(poe), .selected(sel));
  pach_host host (.mclk(mclk), .go(go), .byte_in(hbyte), .ready(flag),
    .write_strobe_n(ws_n), .data_in(din), .busy(hbusy));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(negedge mclk) begin
    seed = xs(seed);
    taken = bvalid & seed[3];
  end
  task automatic give_verdict;
    $display("tests %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic send(input logic [7:0] b, input logic cap);
    int i;
    hbyte = b;
    go = 1'b1;
    got = 1'b0;
    @(negedge mclk);
    #1 go = 1'b0;
    for (i = 0; i < 60 && hbusy !== 1'b0; i++) begin
      @(negedge mclk);
      rs_n = seed[5];
      #1 got = got | bvalid;
      if (bvalid === 1'b1) `CHK(flag, 1'b0)
      `CHK(doe[7], !rs_n)
      if (rs_n === 1'b0) `CHK(dout[7], flag)
    end
    rs_n = 1'b1;
    `CHK(hbusy, 1'b0)
    `CHK(got, cap)
    if (cap) `CHK(bdata, b)
  endtask : send
  initial begin
    rst = 1'b1;
    mode = pach_pkg::PACH_PARALLEL_ASYNC;
    {upg, rs_n, cs} = 3'h7;
    {user, cs_n, uss, pload, go, done} = 6'h00;
    {hbyte, pnext} = 11'h000;
    repeat (5) @(negedge mclk);
    #1 rst = 1'b0;
    `CHK({flag, foe}, 2'h3)
    #1 rs_n = 1'b0;
    #1 `CHK({doe[7], dout[7]}, 2'h3)
    rs_n = 1'b1;
    $display("test status done");
    send(8'hFF, 1'b1);
    send(8'h00, 1'b1);
    for (int k = 0; k < 8; k++) send(seed[15:8], 1'b1);
    $display("test bytes done");
    for (int k = 0; k < 4; k++) begin
      {cs_n, cs} = k[1:0];
      #1 `CHK(sel, exp_sel(k[1:0]))
    end
    send(8'hA5, 1'b0);
    {cs_n, cs} = 2'h1;
    $display("test select done");
    done = 1'b1;
    #1 `CHK({flag, foe}, 2'h3)
    send(8'h5A, 1'b0);
    `CHK({flag, foe}, 2'h3)
    $display("test completion done");
    rs_n = 1'b0;
    for (int k = 0; k < 4; k++) begin
      mode = pach_pkg::pach_mode_type'(k);
      uss = k[0];
      #1 `CHK(foe, mode == pach_pkg::PACH_PARALLEL_ASYNC)
      `CHK(doe[7], mode == pach_pkg::PACH_PARALLEL_ASYNC)
      `CHK(poe, mode != pach_pkg::PACH_ACTIVE_SERIAL)
      `CHK(remote, uss && mode != pach_pkg::PACH_ACTIVE_SERIAL)
    end
    rs_n = 1'b1;
    mode = pach_pkg::PACH_PARALLEL_ASYNC;
    hbyte = seed[7:0];
    pload = 1'b1;
    for (int k = 0; k < 8; k++) begin
      pnext = k[2:0] ^ hbyte[2:0];
      @(negedge mclk);
      #1 `CHK(page, pnext)
    end
    upg = 1'b0;
    pnext = ~pnext;
    @(negedge mclk);
    #1 `CHK(page, ~pnext)
    `CHK(poe, 1'b0)
    pload = 1'b0;
    user = 1'b1;
    @(negedge mclk);
    #1 `CHK({foe, doe}, 9'h000)
    $display("test modes done");
    give_verdict();
  end
  initial begin
    #(25 * 3000);
    bad_count++;
    give_verdict();
  end
endmodule : tb_pach_handshake
